// ---- logic/alarm_pkg.sv ----
package alarm_pkg;

  // ---------------------------------------------------------------
  // alarm map: number = base + 8 * byte + bit
  // ---------------------------------------------------------------
  localparam int unsigned ALARM_BASE  = 1200;
  localparam int unsigned ALARM_BYTES = 32;
  localparam int unsigned RED_BYTES   = 20;
  localparam int unsigned ALARM_BITS  = ALARM_BYTES * 8;
  localparam int unsigned RED_BITS    = RED_BYTES * 8;
  localparam int unsigned PROMPT_BITS = ALARM_BITS - RED_BITS;

  localparam int unsigned ALM_SHIFT_SPIN   = 1214;
  localparam int unsigned ALM_NO_TSEL      = 1215;
  localparam int unsigned ALM_SPIN_RELEASE = 1216;
  localparam int unsigned ALM_RELEASE_SPIN = 1217;
  localparam int unsigned ALM_MAG_STOP     = 1218;
  localparam int unsigned ALM_SPIN_MANIP   = 1219;
  localparam int unsigned ALM_CLAMP_DET    = 1220;
  localparam int unsigned ALM_RELEASE_DET  = 1221;
  localparam int unsigned ALM_ORIENT_DET   = 1225;
  localparam int unsigned ALM_GEAR_FAULT   = 1226;
  localparam int unsigned ALM_START_MANIP  = 1227;

  // user-defined red slots, set by outside logic
  localparam int unsigned USER_SLOTS = 12;
  localparam int unsigned USER_SLOT_NUM [USER_SLOTS] = '{
    1204, 1205, 1207, 1208, 1209, 1210,
    1211, 1212, 1213, 1222, 1223, 1224
  };

  function automatic int unsigned alarm_bit(input int unsigned num);
    return num - ALARM_BASE;
  endfunction

  // ---------------------------------------------------------------
  // switch positions in the synchronised switch vector
  // ---------------------------------------------------------------
  localparam int unsigned SW_COUNT    = 7;
  localparam int unsigned SW_GEAR1    = 0;
  localparam int unsigned SW_GEAR2    = 1;
  localparam int unsigned SW_GEAR3    = 2;
  localparam int unsigned SW_CLAMP    = 3;
  localparam int unsigned SW_RELEASE  = 4;
  localparam int unsigned SW_ORIENT   = 5;
  localparam int unsigned SW_MANIP    = 6;
  localparam logic [6:0]  SW_RESET    = 7'h00;

  // spindle request vector width: fwd, rev, jog, pos, m03, m04, m19
  localparam int unsigned SPIN_REQ_W = 7;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned CYCLES_PER_MS   = CLK_HZ / 1000;
  localparam int unsigned GEAR_TIME_MS    = 2000;
  localparam int unsigned CLAMP_TIME_MS   = 1000;
  localparam int unsigned RELEASE_TIME_MS = 1000;
  localparam int unsigned ORIENT_TIME_MS  = 3000;
  localparam int unsigned TIMER_W         = 32;

  // ---------------------------------------------------------------
  // operating modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_MANUAL = 2'b00,
    MODE_AUTO   = 2'b01,
    MODE_MDI    = 2'b10,
    MODE_DNC    = 2'b11
  } mode_t;

endpackage

// ---- logic/supervision_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

module supervision_timer #(
  parameter int unsigned LIMIT = 1000,
  parameter int unsigned W     = 32
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  input  wire logic i_active,
  input  wire logic i_done,
  output logic      o_expired
);

  localparam logic [W-1:0] LIMIT_W = LIMIT[W-1:0];

  logic [W-1:0] count;

  // ---------------------------------------------------------------
  // count while the output is asserted and the switch has not closed
  // ---------------------------------------------------------------
  // clearing while idle makes every new assertion start from zero
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !i_active || i_done) begin
      count <= '0;
    end else if (count != LIMIT_W) begin
      count <= count + 1'b1;
    end
  end

  // the alarm latches; only system reset takes it away
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_expired <= 1'b0;
    end else if (i_active && !i_done && count == LIMIT_W) begin
      o_expired <= 1'b1;
    end
  end

endmodule // supervision_timer

`default_nettype wire

// ---- logic/alarm_interlock.sv ----
`timescale 1ns/1ps
`default_nettype none

module alarm_interlock #(
  parameter int unsigned GEAR_CYCLES    =
    alarm_pkg::GEAR_TIME_MS * alarm_pkg::CYCLES_PER_MS,
  parameter int unsigned CLAMP_CYCLES   =
    alarm_pkg::CLAMP_TIME_MS * alarm_pkg::CYCLES_PER_MS,
  parameter int unsigned RELEASE_CYCLES =
    alarm_pkg::RELEASE_TIME_MS * alarm_pkg::CYCLES_PER_MS,
  parameter int unsigned ORIENT_CYCLES  =
    alarm_pkg::ORIENT_TIME_MS * alarm_pkg::CYCLES_PER_MS
) (
  input  wire logic                                 i_core_clk,
  input  wire logic                                 i_rst,
  // limit switches, straight from pins
  input  wire logic                                 i_gear1_in_position_switch,
  input  wire logic                                 i_gear2_in_position_switch,
  input  wire logic                                 i_gear3_in_position_switch,
  input  wire logic                                 i_clamp_complete_switch,
  input  wire logic                                 i_release_complete_switch,
  input  wire logic                                 i_orient_position_switch,
  input  wire logic                                 i_manipulator_home_switch,
  // commands from operator panel and program logic
  input  wire logic [1:0]                           i_gear_cmd,
  input  wire logic [alarm_pkg::SPIN_REQ_W-1:0]     i_spin_req,
  input  wire logic                                 i_spin_stop,
  input  wire logic                                 i_release_req,
  input  wire logic                                 i_clamp_req,
  input  wire logic                                 i_orient_cmd,
  input  wire logic                                 i_tool_select_valid,
  input  wire logic                                 i_tool_change,
  input  wire logic                                 i_cycle_start,
  input  wire logic                                 i_cycle_end,
  input  wire alarm_pkg::mode_t                     i_mode,
  input  wire logic                                 i_mag_rotating,
  input  wire logic                                 i_reset_key,
  input  wire logic [alarm_pkg::USER_SLOTS-1:0]     i_user_alarm,
  input  wire logic [alarm_pkg::PROMPT_BITS-1:0]    i_user_prompt,
  // actuator outputs
  output logic                                      o_gear1_select_output,
  output logic                                      o_gear2_select_output,
  output logic                                      o_gear3_select_output,
  output logic                                      o_tool_release_output,
  output logic                                      o_spindle_orient_output,
  output logic                                      o_spindle_run,
  output logic                                      o_cycle_run,
  output logic                                      o_tool_change_go,
  // alarm report
  output logic [alarm_pkg::ALARM_BITS-1:0]          o_alarm,
  output logic                                      o_system_stop,
  output logic                                      o_prompt_active
);

  import alarm_pkg::*;

  localparam int unsigned B_SHIFT_SPIN   = alarm_bit(ALM_SHIFT_SPIN);
  localparam int unsigned B_NO_TSEL      = alarm_bit(ALM_NO_TSEL);
  localparam int unsigned B_SPIN_RELEASE = alarm_bit(ALM_SPIN_RELEASE);
  localparam int unsigned B_RELEASE_SPIN = alarm_bit(ALM_RELEASE_SPIN);
  localparam int unsigned B_MAG_STOP     = alarm_bit(ALM_MAG_STOP);
  localparam int unsigned B_SPIN_MANIP   = alarm_bit(ALM_SPIN_MANIP);
  localparam int unsigned B_CLAMP_DET    = alarm_bit(ALM_CLAMP_DET);
  localparam int unsigned B_RELEASE_DET  = alarm_bit(ALM_RELEASE_DET);
  localparam int unsigned B_ORIENT_DET   = alarm_bit(ALM_ORIENT_DET);
  localparam int unsigned B_GEAR_FAULT   = alarm_bit(ALM_GEAR_FAULT);
  localparam int unsigned B_START_MANIP  = alarm_bit(ALM_START_MANIP);

  logic [SW_COUNT-1:0]   sw_raw;
  logic [SW_COUNT-1:0]   sw_meta;
  logic [SW_COUNT-1:0]   sw_s2;
  logic [SW_COUNT-1:0]   sw_s3;
  logic [SW_COUNT-1:0]   sw;
  logic [2:0]            gear_expired;
  logic                  clamp_expired;
  logic                  release_expired;
  logic                  orient_expired;
  logic                  tsel_valid;
  logic                  released_state;
  logic                  manip_away;
  logic                  spin_any;
  logic                  spin_refuse;
  logic                  start_refuse;
  logic                  mag_event;
  logic [ALARM_BITS-1:0] set_vec;
  logic [ALARM_BITS-1:0] next_alarm;

  // ---------------------------------------------------------------
  // switch synchronisers
  // ---------------------------------------------------------------
  assign sw_raw = {i_manipulator_home_switch,
                   i_orient_position_switch,
                   i_release_complete_switch,
                   i_clamp_complete_switch,
                   i_gear3_in_position_switch,
                   i_gear2_in_position_switch,
                   i_gear1_in_position_switch};

  // three stages; a change counts only when stages two and three agree,
  // which also rejects a single-scan bounce
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sw_meta <= SW_RESET;
      sw_s2   <= SW_RESET;
      sw_s3   <= SW_RESET;
    end else begin
      sw_meta <= sw_raw;
      sw_s2   <= sw_meta;
      sw_s3   <= sw_s2;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sw <= SW_RESET;
    end else begin
      for (int i = 0; i < SW_COUNT; i++) begin
        if (sw_s2[i] == sw_s3[i]) begin
          sw[i] <= sw_s3[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // gear select outputs
  // ---------------------------------------------------------------
  // gear command 1..3 holds that output; 0 drops all of them
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_gear1_select_output <= 1'b0;
      o_gear2_select_output <= 1'b0;
      o_gear3_select_output <= 1'b0;
    end else begin
      o_gear1_select_output <= (i_gear_cmd == 2'h1);
      o_gear2_select_output <= (i_gear_cmd == 2'h2);
      o_gear3_select_output <= (i_gear_cmd == 2'h3);
    end
  end

  // ---------------------------------------------------------------
  // supervision timers
  // ---------------------------------------------------------------
  supervision_timer #(.LIMIT(GEAR_CYCLES), .W(TIMER_W)) u_gear1_timer (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_active   (o_gear1_select_output),
    .i_done     (sw[SW_GEAR1]),
    .o_expired  (gear_expired[0])
  );

  supervision_timer #(.LIMIT(GEAR_CYCLES), .W(TIMER_W)) u_gear2_timer (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_active   (o_gear2_select_output),
    .i_done     (sw[SW_GEAR2]),
    .o_expired  (gear_expired[1])
  );

  supervision_timer #(.LIMIT(GEAR_CYCLES), .W(TIMER_W)) u_gear3_timer (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_active   (o_gear3_select_output),
    .i_done     (sw[SW_GEAR3]),
    .o_expired  (gear_expired[2])
  );

  // clamp supervision runs whenever the release output is low
  supervision_timer #(.LIMIT(CLAMP_CYCLES), .W(TIMER_W)) u_clamp_timer (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_active   (!o_tool_release_output),
    .i_done     (sw[SW_CLAMP]),
    .o_expired  (clamp_expired)
  );

  supervision_timer #(.LIMIT(RELEASE_CYCLES), .W(TIMER_W)) u_rel_timer (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_active   (o_tool_release_output),
    .i_done     (sw[SW_RELEASE]),
    .o_expired  (release_expired)
  );

  // here the fault is the switch staying on, so done means it opened
  supervision_timer #(.LIMIT(ORIENT_CYCLES), .W(TIMER_W)) u_orient_timer (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_active   (o_spindle_orient_output),
    .i_done     (!sw[SW_ORIENT]),
    .o_expired  (orient_expired)
  );

  // ---------------------------------------------------------------
  // interlock conditions
  // ---------------------------------------------------------------
  // a released state is either output high or clamp not yet confirmed
  assign released_state = o_tool_release_output || !sw[SW_CLAMP];
  assign manip_away     = !sw[SW_MANIP];
  assign spin_any       = |i_spin_req;

  // gear fault uses the latched gear alarm, so it holds until reset
  assign spin_refuse = o_alarm[B_GEAR_FAULT] || released_state ||
                       manip_away || o_system_stop;

  assign start_refuse = (i_mode != MODE_MANUAL) && manip_away;

  // new red alarm or reset key while the magazine is turning
  assign mag_event = i_mag_rotating &&
                     (i_reset_key ||
                      (|(set_vec[RED_BITS-1:0] & ~o_alarm[RED_BITS-1:0])));

  // ---------------------------------------------------------------
  // alarm set vector
  // ---------------------------------------------------------------
  always_comb begin
    set_vec = '0;
    set_vec[B_GEAR_FAULT]   = |gear_expired;
    set_vec[B_SHIFT_SPIN]   = spin_any && o_alarm[B_GEAR_FAULT];
    set_vec[B_NO_TSEL]      = i_tool_change && !tsel_valid;
    set_vec[B_SPIN_RELEASE] = spin_any && released_state;
    set_vec[B_RELEASE_SPIN] = i_release_req && o_spindle_run;
    set_vec[B_SPIN_MANIP]   = spin_any && manip_away;
    set_vec[B_CLAMP_DET]    = clamp_expired;
    set_vec[B_RELEASE_DET]  = release_expired;
    set_vec[B_ORIENT_DET]   = orient_expired;
    set_vec[B_START_MANIP]  = i_cycle_start && start_refuse;
    for (int i = 0; i < USER_SLOTS; i++) begin
      set_vec[alarm_bit(USER_SLOT_NUM[i])] = i_user_alarm[i];
    end
    set_vec[ALARM_BITS-1:RED_BITS] = i_user_prompt;
  end

  // reconfirm alarm goes last: it looks at the others
  always_comb begin
    next_alarm = o_alarm | set_vec;
    next_alarm[B_MAG_STOP] = o_alarm[B_MAG_STOP] || mag_event;
  end

  // ---------------------------------------------------------------
  // alarm store and summary flags
  // ---------------------------------------------------------------
  // bits only ever set here, so no event can be lost to a clear
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_alarm <= '0;
    end else begin
      o_alarm <= next_alarm;
    end
  end

  // summaries change on the same edge as the alarm bits
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_system_stop   <= 1'b0;
      o_prompt_active <= 1'b0;
    end else begin
      o_system_stop   <= |next_alarm[RED_BITS-1:0];
      o_prompt_active <= |next_alarm[ALARM_BITS-1:RED_BITS];
    end
  end

  // ---------------------------------------------------------------
  // spindle run
  // ---------------------------------------------------------------
  // a red alarm stops the spindle; prompts leave it alone
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_spindle_run <= 1'b0;
    end else if (i_spin_stop || o_system_stop) begin
      o_spindle_run <= 1'b0;
    end else if (spin_any && !spin_refuse) begin
      o_spindle_run <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // tool release and orientation outputs
  // ---------------------------------------------------------------
  // release only from standstill; clamp is always allowed for safety
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_tool_release_output <= 1'b0;
    end else if (i_clamp_req) begin
      o_tool_release_output <= 1'b0;
    end else if (i_release_req && !o_spindle_run) begin
      o_tool_release_output <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_spindle_orient_output <= 1'b0;
    end else begin
      o_spindle_orient_output <= i_orient_cmd && !o_system_stop;
    end
  end

  // ---------------------------------------------------------------
  // tool select memory and tool change
  // ---------------------------------------------------------------
  // a valid select is consumed by the change that uses it
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tsel_valid <= 1'b0;
    end else if (i_tool_select_valid) begin
      tsel_valid <= 1'b1;
    end else if (i_tool_change) begin
      tsel_valid <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_tool_change_go <= 1'b0;
    end else begin
      o_tool_change_go <= i_tool_change && tsel_valid &&
                          !o_system_stop;
    end
  end

  // ---------------------------------------------------------------
  // cycle run
  // ---------------------------------------------------------------
  // start in manual mode is not a program start and is ignored
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_cycle_run <= 1'b0;
    end else if (i_cycle_end || o_system_stop) begin
      o_cycle_run <= 1'b0;
    end else if (i_cycle_start && (i_mode != MODE_MANUAL) &&
                 !start_refuse) begin
      o_cycle_run <= 1'b1;
    end
  end

endmodule // alarm_interlock

`default_nettype wire

// ---- tb/alarm_interlock_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module alarm_interlock_properties #(
  parameter int unsigned GEAR_CYCLES = 30
) (
  input wire logic                          i_core_clk,
  input wire logic                          i_rst,
  input wire logic                          i_gear1_in_position_switch,
  input wire logic [alarm_pkg::SPIN_REQ_W-1:0] i_spin_req,
  input wire logic                          i_release_req,
  input wire logic                          i_tool_change,
  input wire logic                          i_cycle_start,
  input wire alarm_pkg::mode_t              i_mode,
  input wire logic                          i_mag_rotating,
  input wire logic                          i_reset_key,
  input wire logic [alarm_pkg::USER_SLOTS-1:0] i_user_alarm,
  input wire logic                          o_gear1_select_output,
  input wire logic                          o_tool_release_output,
  input wire logic                          o_spindle_run,
  input wire logic                          o_cycle_run,
  input wire logic                          o_tool_change_go,
  input wire logic [alarm_pkg::ALARM_BITS-1:0] o_alarm,
  input wire logic                          o_system_stop,
  input wire logic                          o_prompt_active
);
  import alarm_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // gear wait; slack covers switch filter lag
  int unsigned gear_wait;
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !o_gear1_select_output || i_gear1_in_position_switch) begin
      gear_wait <= 0;
    end else begin
      gear_wait <= gear_wait + 1;
    end
  end
  sequence s_spin_released;
    (|i_spin_req) && o_tool_release_output;
  endsequence
  sequence s_release_spin;
    i_release_req && o_spindle_run;
  endsequence
  spin_released_a: assert property (s_spin_released |=>
    o_alarm[16] && !$rose(o_spindle_run)) else $error("spin not refused");
  release_spin_a: assert property (s_release_spin |=>
    o_alarm[17] && !$rose(o_tool_release_output)) else $error("bad release");
  reconfirm_a: assert property (i_mag_rotating && i_reset_key
    |=> o_alarm[18]) else $error("no reconfirm alarm");
  tool_go_a: assert property (o_tool_change_go |->
    $past(i_tool_change) && !$past(o_system_stop)) else $error("stray go");
  start_manip_a: assert property ($rose(o_alarm[27]) |->
    $past(i_cycle_start) && $past(i_mode) != MODE_MANUAL)
    else $error("stray start alarm");
  red_stop_a: assert property (o_system_stop == (|o_alarm[RED_BITS-1:0]))
    else $error("stop flag wrong");
  stop_run_a: assert property (o_system_stop |=>
    !o_spindle_run && !o_cycle_run) else $error("runs under stop");
  prompt_flag_a: assert property (
    o_prompt_active == (|o_alarm[ALARM_BITS-1:RED_BITS]))
    else $error("prompt flag wrong");
  user_slot_a: assert property (i_user_alarm[0] |=> o_alarm[4])
    else $error("slot lost");
  alarm_sticky_a: assert property (!$past(i_rst) |->
    ($past(o_alarm) & ~o_alarm) == '0) else $error("alarm bit fell");
  gear_timer_a: assert property (gear_wait <= GEAR_CYCLES + 8
    || o_alarm[26]) else $error("gear alarm late");
endmodule // alarm_interlock_properties
bind alarm_interlock alarm_interlock_properties
  #(.GEAR_CYCLES(GEAR_CYCLES)) u_alarm_interlock_properties (.*);
`default_nettype wire

// ---- tb/machine_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module machine_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_slow,
  input  wire logic       i_away,
  input  wire logic [3:0] i_stuck,
  input  wire logic [2:0] i_gear_out,
  input  wire logic       i_release_out,
  input  wire logic       i_orient_out,
  output logic      [2:0] o_gear_sw,
  output logic            o_clamp_sw,
  output logic            o_release_sw,
  output logic            o_orient_sw,
  output logic            o_home_sw
);
  // actuator history; slow tap still lands well inside every timer
  logic [79:0] hist = '0;
  logic [4:0]  seen;
  always_ff @(posedge i_core_clk) begin
    hist <= {hist[74:0], i_orient_out, i_release_out, i_gear_out};
  end
  assign seen = i_slow ? hist[19:15] : hist[9:5];
  // a stuck switch holds its fault level: gear, clamp and release stay off, orient stays on
  assign o_gear_sw    = seen[2:0] & ~{3{i_stuck[0]}};
  assign o_clamp_sw   = !seen[3] && !i_stuck[1];
  assign o_release_sw = seen[3] && !i_stuck[2];
  assign o_orient_sw  = !seen[4] || i_stuck[3];
  assign o_home_sw    = !i_away;
endmodule // machine_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import alarm_pkg::*;
  localparam int unsigned N = 30;
  logic i_core_clk = '0, i_rst = 1'b1, slow = '0, away = '0;
  logic i_spin_stop = '0, i_release_req = '0, i_clamp_req = '0;
  logic i_orient_cmd = '0, i_tool_select_valid = '0, i_reset_key = '0;
  logic i_tool_change = '0, i_cycle_start = '0, i_cycle_end = '0;
  logic i_mag_rotating = '0;
  logic [3:0] stuck = '0;
  logic [1:0] i_gear_cmd = '0;
  logic [SPIN_REQ_W-1:0] i_spin_req = '0;
  mode_t i_mode = MODE_MANUAL;
  logic [USER_SLOTS-1:0] i_user_alarm = '0;
  logic [PROMPT_BITS-1:0] i_user_prompt = '0;
  wire logic [2:0] gear_sw;
  wire logic clamp_sw, release_sw, orient_sw, home_sw;
  logic o_gear1_select_output, o_gear2_select_output, o_gear3_select_output;
  logic o_tool_release_output, o_spindle_orient_output, o_spindle_run;
  logic o_cycle_run, o_tool_change_go, o_system_stop, o_prompt_active;
  logic [ALARM_BITS-1:0] o_alarm, ex = '0, last = '0;
  logic [ALARM_BITS-1:0] q [$];
  logic [31:0] seed = 32'hB542E26E;
  int error_cnt = 0, checked = 0;
  alarm_interlock #(.GEAR_CYCLES(N), .CLAMP_CYCLES(N), .RELEASE_CYCLES(N),
    .ORIENT_CYCLES(N)) u_alarm_interlock (.i_core_clk, .i_rst,
    .i_gear1_in_position_switch(gear_sw[0]),
    .i_gear2_in_position_switch(gear_sw[1]),
    .i_gear3_in_position_switch(gear_sw[2]),
    .i_clamp_complete_switch(clamp_sw), .i_release_complete_switch(release_sw),
    .i_orient_position_switch(orient_sw), .i_manipulator_home_switch(home_sw),
    .i_gear_cmd, .i_spin_req, .i_spin_stop, .i_release_req, .i_clamp_req,
    .i_orient_cmd, .i_tool_select_valid, .i_tool_change, .i_cycle_start,
    .i_cycle_end, .i_mode, .i_mag_rotating, .i_reset_key, .i_user_alarm,
    .i_user_prompt, .o_gear1_select_output, .o_gear2_select_output,
    .o_gear3_select_output, .o_tool_release_output, .o_spindle_orient_output,
    .o_spindle_run, .o_cycle_run, .o_tool_change_go, .o_alarm, .o_system_stop,
    .o_prompt_active);
  machine_model u_machine_model (.i_core_clk, .i_slow(slow), .i_away(away),
    .i_stuck(stuck), .i_gear_out({o_gear3_select_output,
    o_gear2_select_output, o_gear1_select_output}),
    .i_release_out(o_tool_release_output),
    .i_orient_out(o_spindle_orient_output), .o_gear_sw(gear_sw),
    .o_clamp_sw(clamp_sw), .o_release_sw(release_sw),
    .o_orient_sw(orient_sw), .o_home_sw(home_sw));
  initial forever #20 i_core_clk = ~i_core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic look(ref logic seen, input logic exp);
    @(negedge i_core_clk);
    check(seen, exp);
  endtask
  task automatic note(input int a, input int b = -1);
    ex[a] = 1'b1;
    if (b >= 0)
      ex[b] = 1'b1;
    q.push_back(ex);
  endtask
  // one-cycle command pulse; spindle kind picked by v
  task automatic hit(input int w, input int v);
    @(posedge i_core_clk);
    case (w)
      0: i_release_req <= 1'b1;
      1: i_clamp_req <= 1'b1;
      2: i_spin_req <= SPIN_REQ_W'(1) << v;
      3: i_tool_select_valid <= 1'b1;
      4: i_tool_change <= 1'b1;
      5: i_cycle_start <= 1'b1;
      default: i_reset_key <= 1'b1;
    endcase
    @(posedge i_core_clk);
    {i_release_req, i_clamp_req, i_tool_select_valid, i_reset_key} <= '0;
    {i_tool_change, i_cycle_start, i_spin_req} <= '0;
    seed = lfsr(seed);
  endtask
  // alarms latch: each scenario starts from reset
  task automatic restart();
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    {slow, away, i_mag_rotating, i_orient_cmd, stuck, i_gear_cmd} <= '0;
    i_mode <= MODE_MANUAL;
    {i_user_alarm, i_user_prompt} <= '0;
    ex = '0;
    cyc(12);
    i_rst <= 1'b0;
    cyc(10);
  endtask
  // timed alarm: quiet before the limit, set soon after
  task automatic timed(input int b);
    note(b);
    repeat (N - 4) @(negedge i_core_clk);
    check(o_alarm[b], 1'b0);
    repeat (14) @(negedge i_core_clk);
    check(o_alarm[b], 1'b1);
    cyc(1);
  endtask
  // each alarm change takes the oldest note
  initial forever begin
    @(negedge i_core_clk);
    if (i_rst) begin
      last = '0;
    end else if (o_alarm !== last) begin
      last = o_alarm;
      check(o_alarm, (q.size() > 0) ? q.pop_front() : ~o_alarm);
    end
  end
  initial begin
    #(40 * 8000);
    error_cnt++;
    conclude();
  end
  initial begin
    for (int k = 0; k < SPIN_REQ_W; k++) begin
      restart();
      slow <= 1'b1;
      hit(0, 0);
      cyc(24);
      hit(2, k);
      note(16);
      look(o_spindle_run, 1'b0);
    end
    restart();
    hit(2, int'(seed % SPIN_REQ_W));
    look(o_spindle_run, 1'b1);
    cyc(1);
    i_mag_rotating <= 1'b1;
    hit(0, 0);
    note(17, 18);
    look(o_tool_release_output, 1'b0);
    restart();
    i_mag_rotating <= 1'b1;
    hit(6, 0);
    note(18);
    // no cycle start or spindle while away: zero return first
    restart();
    away <= 1'b1;
    cyc(8);
    hit(5, 0);
    look(o_cycle_run, 1'b0);
    cyc(1);
    i_mode <= mode_t'(2'(1 + seed % 3));
    hit(5, 0);
    note(27);
    hit(2, 0);
    note(27, 19);
    look(o_spindle_run, 1'b0);
    restart();
    hit(3, 0);
    hit(4, 0);
    look(o_tool_change_go, 1'b1);
    hit(4, 0);
    note(15);
    look(o_tool_change_go, 1'b0);
    for (int g = 1; g < 4; g++) begin
      restart();
      slow <= 1'b1;
      i_gear_cmd <= 2'(g);
      cyc(N + 20);
      i_gear_cmd <= 2'h0;
      stuck <= 4'h1;
      cyc(4);
      i_gear_cmd <= 2'(g);
      timed(26);
    end
    hit(2, 1);
    note(26, 14);
    restart();
    stuck <= 4'h4;
    hit(0, 0);
    timed(21);
    restart();
    hit(0, 0);
    cyc(20);
    stuck <= 4'h2;
    hit(1, 0);
    timed(20);
    restart();
    i_orient_cmd <= 1'b1;
    cyc(N + 20);
    i_orient_cmd <= 1'b0;
    stuck <= 4'h8;
    cyc(4);
    i_orient_cmd <= 1'b1;
    timed(25);
    restart();
    i_user_prompt <= {3{seed}};
    ex[ALARM_BITS-1:RED_BITS] = {3{seed}};
    q.push_back(ex);
    cyc(2);
    look(o_system_stop, 1'b0);
    look(o_prompt_active, 1'b1);
    cyc(1);
    i_user_alarm <= seed[11:0] | 12'h001;
    for (int k = 0; k < USER_SLOTS; k++)
      if (seed[k] || k == 0)
        ex[USER_SLOT_NUM[k] - ALARM_BASE] = 1'b1;
    q.push_back(ex);
    cyc(2);
    look(o_system_stop, 1'b1);
    check(q.size(), 0);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
